// ---- core/sie_pkg.sv ----
package sie_pkg;

  localparam logic [11:0] OFS_ADDR_WAKE = 12'h000;
  localparam logic [11:0] OFS_OUT_STALL = 12'h004;
  localparam logic [11:0] OFS_IN_STALL  = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00C;
  localparam logic [11:0] OFS_ACTIVE    = 12'h010;

  localparam int BIT_NAK_MASK  = 7;
  localparam int BIT_INTEGRITY = 6;
  localparam int BIT_NO_REPLY  = 4;
  localparam int BIT_IN_TOKEN  = 3;
  localparam int BIT_OUT_TOKEN = 2;
  localparam int BIT_FIFO_ERR  = 1;
  localparam int BIT_DEFERRED  = 0;

  localparam logic [7:0] RESET_ADDR_WAKE = 8'h00;
  localparam logic [7:0] RESET_STALL     = 8'h00;
  localparam logic [7:0] RESET_STATUS    = 8'h00;
  localparam logic [7:0] STATUS_WMASK    = 8'hC7;

  // Events reported by the serial engine for one clock cycle each.
  typedef struct packed {
    logic       bus_reset;
    logic       setup_token;
    logic       in_token;
    logic       out_token;
    logic       out_zero_len;
    logic       nak_sent;
    logic       rx_integrity_error;
    logic       no_reply;
    logic       fifo_error;
    logic       status_in_ok;
    logic [7:0] in_fault;
    logic [7:0] out_fault;
  } sie_event_t;

endpackage : sie_pkg

// ---- core/usb_sie_address_stall_status.sv ----
`timescale 1ns/10ps
module usb_sie_address_stall_status #(
  parameter int NUM_EP = 8
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire sie_pkg::sie_event_t evt,
  input  wire logic                bus_suspended_flag,
  output logic      [6:0]          active_address,
  output logic                     remote_wakeup_enable,
  output logic      [7:0]          in_stall,
  output logic      [7:0]          out_stall,
  output logic                     usb_irq
);
  import sie_pkg::*;

  logic [7:0] device_address_wake;
  logic [7:0] out_stall_flags;
  logic [7:0] in_stall_flags;
  logic [7:0] serial_engine_status;
  logic [6:0] addr_live;
  logic       addr_pending;
  logic       bus_suspended_flag_q;
  logic       irq_q;

  // Masks of implemented stall bits for the configured endpoint count.
  localparam logic [7:0] IN_IMPL  = 8'(({8'h00, 8'hFF} >> (8 - NUM_EP)));
  localparam logic [7:0] OUT_IMPL = IN_IMPL & 8'hFE;

  // Bus decode: every access completes with no wait state.
  wire        wr_cycle  = psel & penable & pwrite;
  wire        lane0     = pstrb[0];
  wire        hit_addr  = paddr == OFS_ADDR_WAKE;
  wire        hit_out   = paddr == OFS_OUT_STALL;
  wire        hit_in    = paddr == OFS_IN_STALL;
  wire        hit_stat  = paddr == OFS_STATUS;
  wire        hit_act   = paddr == OFS_ACTIVE;
  wire        mapped    = hit_addr | hit_out | hit_in | hit_stat | hit_act;
  wire        wr_addr   = wr_cycle & lane0 & hit_addr;
  wire        wr_out    = wr_cycle & lane0 & hit_out;
  wire        wr_in     = wr_cycle & lane0 & hit_in;
  wire        wr_stat   = wr_cycle & lane0 & hit_stat;
  wire  [7:0] wbyte     = pwdata[7:0];
  wire        deferred  = serial_engine_status[BIT_DEFERRED];
  wire        stall_clr = evt.bus_reset | evt.setup_token;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read mux; unimplemented bits were never stored and read as zero.
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit_addr) rbyte = device_address_wake;
    if (hit_out)  rbyte = out_stall_flags & OUT_IMPL;
    if (hit_in)   rbyte = in_stall_flags & IN_IMPL;
    if (hit_stat) rbyte = serial_engine_status;
    if (hit_act)  rbyte = {1'b0, addr_live};
  end

  // Read data is registered at the setup phase so it is stable in access.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) prdata <= {24'h000000, rbyte};
  end

  // Address and wakeup register, reset to zero.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) device_address_wake <= RESET_ADDR_WAKE;
    else if (wr_addr) device_address_wake <= wbyte;
  end

  // Stall flags: improper operation sets, reset and SETUP clear, set wins.
  wire [7:0] next_out_stall = (wr_out ? wbyte : (stall_clr ? 8'h00 : out_stall_flags))
                              | evt.out_fault;
  wire [7:0] next_in_stall  = (wr_in ? wbyte : (stall_clr ? 8'h00 : in_stall_flags))
                              | evt.in_fault;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_stall_flags <= RESET_STALL;
      in_stall_flags  <= RESET_STALL;
    end else begin
      out_stall_flags <= next_out_stall & OUT_IMPL;
      in_stall_flags  <= next_in_stall & IN_IMPL;
    end
  end

  // Status: firmware writes writable bits, hardware sets override clears.
  logic [7:0] next_status;
  always_comb begin
    next_status = serial_engine_status;
    if (wr_stat) next_status = (wbyte & STATUS_WMASK) | (serial_engine_status & ~STATUS_WMASK);
    if (evt.setup_token) next_status[BIT_OUT_TOKEN] = 1'b0;
    if (evt.rx_integrity_error) next_status[BIT_INTEGRITY] = 1'b1;
    if (evt.no_reply) next_status[BIT_NO_REPLY] = 1'b1;
    if (wr_stat && !wbyte[BIT_NO_REPLY] && !evt.no_reply) next_status[BIT_NO_REPLY] = 1'b0;
    if (evt.in_token) next_status[BIT_IN_TOKEN] = 1'b1;
    else if (evt.out_token | evt.setup_token) next_status[BIT_IN_TOKEN] = 1'b0;
    if (evt.out_token && !evt.out_zero_len) next_status[BIT_OUT_TOKEN] = 1'b1;
    if (evt.fifo_error) next_status[BIT_FIFO_ERR] = 1'b1;
    next_status[5] = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) serial_engine_status <= RESET_STATUS;
    else serial_engine_status <= next_status;
  end

  // Address in use by the engine: immediate or deferred until status IN.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_live    <= 7'h00;
      addr_pending <= 1'b0;
    end else if (wr_addr && !deferred) begin
      addr_live    <= wbyte[7:1];
      addr_pending <= 1'b0;
    end else if (wr_addr) begin
      addr_pending <= 1'b1;
    end else if (addr_pending && evt.status_in_ok) begin
      addr_live    <= device_address_wake[7:1];
      addr_pending <= 1'b0;
    end
  end

  // Interrupt: unmasked NAK or a rising suspend indication gives a pulse.
  wire bus_suspended_flag_rise = bus_suspended_flag & ~bus_suspended_flag_q;
  wire nak_irq   = evt.nak_sent & ~serial_engine_status[BIT_NAK_MASK];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_suspended_flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      bus_suspended_flag_q <= bus_suspended_flag;
      irq_q  <= nak_irq | bus_suspended_flag_rise;
    end
  end

  assign usb_irq              = irq_q;
  assign active_address       = addr_live;
  assign remote_wakeup_enable = device_address_wake[0];
  assign in_stall             = in_stall_flags;
  assign out_stall            = out_stall_flags;

  AST_STALL_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
    (stall_clr && !wr_in && evt.in_fault == 8'h00) |=> in_stall_flags == 8'h00)
    else $error("IN stall not cleared by reset or SETUP");
  AST_OUT_STALL: assert property (@(posedge clock) disable iff (!rst_b)
    evt.out_fault[1] && NUM_EP > 1 |=> out_stall_flags[1])
    else $error("OUT stall not set on fault");
  AST_OUT_BIT0: assert property (@(posedge clock) disable iff (!rst_b)
    out_stall_flags[0] == 1'b0)
    else $error("OUT stall bit 0 set");
  AST_NAK_IRQ: assert property (@(posedge clock) disable iff (!rst_b)
    evt.nak_sent && !serial_engine_status[BIT_NAK_MASK] |=> usb_irq)
    else $error("NAK did not raise interrupt");
  AST_NAK_MASK: assert property (@(posedge clock) disable iff (!rst_b)
    evt.nak_sent && serial_engine_status[BIT_NAK_MASK] && !bus_suspended_flag_rise |=> !usb_irq)
    else $error("Masked NAK raised interrupt");
  AST_INTEGRITY: assert property (@(posedge clock) disable iff (!rst_b)
    evt.rx_integrity_error |=> serial_engine_status[BIT_INTEGRITY])
    else $error("Integrity flag not set");
  AST_OUT_ZLP: assert property (@(posedge clock) disable iff (!rst_b)
    evt.out_token && evt.out_zero_len && !wr_stat && !evt.setup_token
    |=> $stable(serial_engine_status[BIT_OUT_TOKEN]))
    else $error("Zero length OUT changed flag");
  AST_FIFO_ERR: assert property (@(posedge clock) disable iff (!rst_b)
    serial_engine_status[BIT_FIFO_ERR] && !wr_stat |=> serial_engine_status[BIT_FIFO_ERR])
    else $error("FIFO error flag lost");
  AST_IMMEDIATE: assert property (@(posedge clock) disable iff (!rst_b)
    wr_addr && !deferred |=> active_address == $past(wbyte[7:1]))
    else $error("Address not adopted at once");
  AST_DEFER: assert property (@(posedge clock) disable iff (!rst_b)
    wr_addr && deferred && addr_live != wbyte[7:1] |=> active_address != device_address_wake[7:1])
    else $error("Deferred address taken early");
  AST_SUSPEND: assert property (@(posedge clock) disable iff (!rst_b)
    bus_suspended_flag_rise |=> usb_irq)
    else $error("Suspend entry gave no interrupt");

endmodule : usb_sie_address_stall_status

// ---- verification/sie_host_model.sv ----
`timescale 1ns/10ps
// Serial engine on the host side: it reports each bus event for one cycle.
module sie_host_model (
  input  wire logic        clock,
  output sie_pkg::sie_event_t evt
);
  import sie_pkg::*;
  // The event bus idles at all zeros between reported events.
  initial evt = '0;
  // Raises one event word for exactly one clock cycle, starting just after an edge.
  task automatic pulse(input sie_event_t e);
    evt <= e;
    @(posedge clock);
    evt <= '0;
  endtask : pulse
endmodule : sie_host_model

// ---- verification/usb_sie_address_stall_status_test.sv ----
`timescale 1ns/10ps
module usb_sie_address_stall_status_test;
  import sie_pkg::*;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, slverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        bus_suspended_flag, remote_wakeup_enable, usb_irq;
  logic [6:0]  active_address;
  logic [7:0]  in_stall, out_stall;
  sie_event_t  evt, e;
  int          err_count = 0, check_count = 0, n;
  usb_sie_address_stall_status dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .bus_suspended_flag(bus_suspended_flag), .active_address(active_address),
    .remote_wakeup_enable(remote_wakeup_enable), .in_stall(in_stall),
    .out_stall(out_stall), .usb_irq(usb_irq));
  sie_host_model host (.clock(clock), .evt(evt));
  // Free-running system clock of 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // One APB transfer; it holds the request until pready is seen high at an edge or 50 edges have passed.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata; slverr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge keeps the next call from driving psel again in this time step.
    @(posedge clock);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Counts interrupt pulses over the next four edges.
  task automatic irqs;
    n = 0;
    repeat (4) begin
      @(posedge clock);
      if (usb_irq === 1'b1) n++;
    end
  endtask : irqs
  // Reset values, then an unmapped address that must be refused.
  task automatic t_reset;
    logic [11:0] a [4] = '{OFS_ADDR_WAKE, OFS_OUT_STALL, OFS_IN_STALL, OFS_STATUS};
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, slverr}, 32'h1);
  endtask : t_reset
  // Address field and wakeup enable share one register; deferral is off.
  task automatic t_addr;
    apb(1'b1, OFS_ADDR_WAKE, 32'hA5);
    apb(1'b0, OFS_ADDR_WAKE, 32'h0);
    chk(rd, 32'hA5);
    chk({25'h0, active_address}, 32'h52);
    chk({31'h0, remote_wakeup_enable}, 32'h1);
  endtask : t_addr
  // Stall bits: written, set by faults, cleared by SETUP and bus reset.
  task automatic t_stall;
    apb(1'b1, OFS_OUT_STALL, 32'hFF);
    apb(1'b1, OFS_IN_STALL, 32'hFF);
    apb(1'b0, OFS_OUT_STALL, 32'h0);
    chk(rd, 32'hFE);
    apb(1'b0, OFS_IN_STALL, 32'h0);
    chk(rd, 32'hFF);
    e = '0; e.setup_token = 1'b1; host.pulse(e);
    apb(1'b0, OFS_IN_STALL, 32'h0);
    chk(rd | {24'h0, out_stall}, 32'h0);
    e = '0; e.in_fault = 8'h81; e.out_fault = 8'h41; host.pulse(e);
    @(posedge clock);
    chk({16'h0, in_stall, out_stall}, 32'h8140);
    e = '0; e.bus_reset = 1'b1; host.pulse(e);
    @(posedge clock);
    chk({16'h0, in_stall, out_stall}, 32'h0);
  endtask : t_stall
  // Status flags set by events and cleared by firmware or SETUP.
  task automatic t_status;
    e = '0; e.rx_integrity_error = 1'b1; e.no_reply = 1'b1; e.fifo_error = 1'b1;
    e.out_token = 1'b1; host.pulse(e);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h56);
    e = '0; e.in_token = 1'b1; host.pulse(e);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h08, 32'h08);
    apb(1'b1, OFS_STATUS, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'hC7, 32'h0);
    e = '0; e.out_token = 1'b1; e.out_zero_len = 1'b1; host.pulse(e);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h04, 32'h0);
    e = '0; e.out_token = 1'b1; host.pulse(e);
    e = '0; e.setup_token = 1'b1; host.pulse(e);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h04, 32'h0);
  endtask : t_status
  // NAK interrupt with mask clear and set, then a suspend rise.
  task automatic t_irq;
    e = '0; e.nak_sent = 1'b1; host.pulse(e);
    irqs;
    chk(n, 1);
    apb(1'b1, OFS_STATUS, 32'h80);
    host.pulse(e);
    irqs;
    chk(n, 0);
    bus_suspended_flag <= 1'b1;
    irqs;
    chk(n, 1);
    bus_suspended_flag <= 1'b0;
  endtask : t_irq
  // Deferred address update waits for a successful status IN.
  task automatic t_defer;
    apb(1'b1, OFS_STATUS, 32'h01);
    e = '0; e.setup_token = 1'b1; host.pulse(e);
    apb(1'b1, OFS_ADDR_WAKE, 32'h20);
    apb(1'b0, OFS_ADDR_WAKE, 32'h0);
    chk({25'h0, active_address}, 32'h52);
    e = '0; e.status_in_ok = 1'b1; host.pulse(e);
    @(posedge clock);
    chk({25'h0, active_address}, 32'h10);
    apb(1'b1, OFS_STATUS, 32'h00);
  endtask : t_defer
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog far beyond the roughly 110 cycles the tests need.
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
  // Reset for twelve cycles, then the scenarios in turn.
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pstrb = 4'h0; bus_suspended_flag = 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset;
    t_addr;
    t_stall;
    t_status;
    t_irq;
    t_defer;
    finish_test;
  end
endmodule : usb_sie_address_stall_status_test
